// File: dprpd_core.sv
// DRAM-side bank state, refresh, self refresh and power-down control.
// Assumes command pins and the memory clock arrive from outside and are synchronised here;
// a command is taken on each rising memory-clock edge found by sampling that clock.
`timescale 1ns/1ps
`default_nettype none
`include "dprpd_consts.svh"

module dprpd_core
	import dprpd_pkg::*;
#(
	parameter int unsigned RFC_CYC  = `DPRPD_RFC_CYC,
	parameter int unsigned XSRD_CYC = `DPRPD_XSRD_CYC
)
(
	input  wire logic                        CLOCK_I,
	input  wire logic                        RESET_N_I,
	input  wire logic                        MEM_CK_I,
	input  wire logic                        CKE_I,
	input  wire logic                        CS_N_I,
	input  wire logic                        RAS_N_I,
	input  wire logic                        CAS_N_I,
	input  wire logic                        WE_N_I,
	input  wire logic [`DPRPD_BA_W-1:0]      BA_I,
	input  wire logic                        A10_I,
	output logic      [`DPRPD_NUM_BANKS-1:0] BANK_OPEN_O,
	output logic      [2:0]                  STATE_O,
	output logic                             REFRESH_BUSY_O,
	output logic                             BUFFERS_EN_O,
	output logic                             DLL_FROZEN_O,
	output logic                             READ_READY_O
);

	// Two-stage synchronisers for every input pin except the core clock and reset.
	logic [9:0]   sync1;
	logic [9:0]   sync2;
	logic         ck_prev;
	logic         ck_rise;
	logic         cke_prev;
	dprpd_pins_t  pins;
	dprpd_cmd_t   cmd;
	dprpd_state_t state;
	logic [`DPRPD_CNT_W-1:0] rfc_cnt;
	logic [`DPRPD_CNT_W-1:0] xsrd_cnt;

	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
		begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
		end
		else
		begin
			sync1 <= {MEM_CK_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, BA_I, A10_I};
			sync2 <= sync1;
		end
	end

	assign pins    = dprpd_pins_t'(sync2[7:0]);
	assign ck_rise = sync2[9] && !ck_prev;

	// Pins are active low; the code that no state here uses decodes as a deselect.
	always_comb
	begin
		cmd = DPRPD_CMD_DES;
		if (!pins.cs_n)
		begin
			case ({pins.ras_n, pins.cas_n, pins.we_n})
				3'b111: cmd = DPRPD_CMD_NOP;
				3'b011: cmd = DPRPD_CMD_ACT;
				3'b010: cmd = DPRPD_CMD_PRE;
				3'b001: cmd = DPRPD_CMD_REF;
				3'b101: cmd = DPRPD_CMD_RD;
				3'b100: cmd = DPRPD_CMD_WR;
				3'b000: cmd = DPRPD_CMD_MRS;
				3'b110: cmd = DPRPD_CMD_DES;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
		begin
			ck_prev  <= 1'b0;
			cke_prev <= 1'b1;
		end
		else
		begin
			ck_prev <= sync2[9];
			if (ck_rise)
				cke_prev <= sync2[8];
		end
	end

	// Bank open state follows activates and precharges; all-bank with A10.
	// per-bank tracking
	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
			BANK_OPEN_O <= '0;
		else if (ck_rise && sync2[8] && cke_prev && state == DPRPD_ST_IDLE)
		begin
			if (cmd == DPRPD_CMD_ACT)
				BANK_OPEN_O[pins.ba] <= 1'b1;
			else if (cmd == DPRPD_CMD_PRE && pins.a10)
				BANK_OPEN_O <= '0;
			else if (cmd == DPRPD_CMD_PRE)
				BANK_OPEN_O[pins.ba] <= 1'b0;
		end
	end

	// Command decoding happens only on real memory-clock edges.
	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
		begin
			state   <= DPRPD_ST_IDLE;
			rfc_cnt <= '0;
		end
		else
		begin
			if (rfc_cnt != '0)
				rfc_cnt <= rfc_cnt - 1'b1;
			if (ck_rise)
			begin
				unique case (state)
					DPRPD_ST_IDLE:
					begin
						if (cke_prev && !sync2[8] && cmd == DPRPD_CMD_REF && BANK_OPEN_O == '0)
							state <= DPRPD_ST_SELFREF;
						else if (cke_prev && !sync2[8] &&
							(cmd == DPRPD_CMD_NOP || cmd == DPRPD_CMD_DES))
						begin
							if (BANK_OPEN_O == '0)
								state <= DPRPD_ST_PPD;
							else
								state <= DPRPD_ST_APD;
						end
						else if (sync2[8] && cmd == DPRPD_CMD_REF)
						begin
							state   <= DPRPD_ST_REFRESH;
							rfc_cnt <= `DPRPD_CNT_W'(RFC_CYC - 1);
						end
					end
					DPRPD_ST_REFRESH:
					begin
						if (rfc_cnt == '0)
							state <= DPRPD_ST_IDLE;
					end
					DPRPD_ST_SELFREF,
					DPRPD_ST_PPD,
					DPRPD_ST_APD:
					begin
						if (sync2[8])
							state <= DPRPD_ST_IDLE;
					end
					default:
						state <= DPRPD_ST_IDLE;
				endcase
			end
			else if (state == DPRPD_ST_REFRESH && rfc_cnt == '0)
				state <= DPRPD_ST_IDLE;
		end
	end

	// Read readiness after self refresh exit counts memory-clock edges.
	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
			xsrd_cnt <= '0;
		else if (ck_rise && state == DPRPD_ST_SELFREF && sync2[8])
			xsrd_cnt <= `DPRPD_CNT_W'(XSRD_CYC);
		else if (ck_rise && xsrd_cnt != '0)
			xsrd_cnt <= xsrd_cnt - 1'b1;
	end

	// Registered status outputs.
	always_ff @(posedge CLOCK_I)
	begin
		if (!RESET_N_I)
		begin
			STATE_O        <= 3'h0;
			REFRESH_BUSY_O <= 1'b0;
			BUFFERS_EN_O   <= 1'b1;
			DLL_FROZEN_O   <= 1'b0;
			READ_READY_O   <= 1'b1;
		end
		else
		begin
			STATE_O        <= state;
			REFRESH_BUSY_O <= (state == DPRPD_ST_REFRESH);
			BUFFERS_EN_O   <= (state == DPRPD_ST_IDLE) || (state == DPRPD_ST_REFRESH);
			DLL_FROZEN_O   <= (state == DPRPD_ST_PPD) || (state == DPRPD_ST_SELFREF);
			READ_READY_O   <= (xsrd_cnt == '0) && (state != DPRPD_ST_SELFREF);
		end
	end

	AST_PRE_ALL: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ck_rise && sync2[8] && cke_prev && state == DPRPD_ST_IDLE
		&& cmd == DPRPD_CMD_PRE && pins.a10) |=> BANK_OPEN_O == '0)
		else $error("precharge-all left a bank open");
	AST_PRE_ONE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ck_rise && sync2[8] && cke_prev && state == DPRPD_ST_IDLE
		&& cmd == DPRPD_CMD_PRE && !pins.a10) |=> !BANK_OPEN_O[$past(pins.ba)])
		else $error("single precharge did not close bank");
	AST_REF_BUSY: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$rose(state == DPRPD_ST_REFRESH) |-> (state == DPRPD_ST_REFRESH)[*8])
		else $error("refresh ended too early");
	AST_SR_IDLE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$rose(state == DPRPD_ST_SELFREF) |-> $past(BANK_OPEN_O) == '0)
		else $error("self refresh with open bank");
	AST_PD_TYPE: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$rose(state == DPRPD_ST_APD) |-> $past(BANK_OPEN_O) != '0)
		else $error("active power-down with all banks idle");
	AST_BUF_OFF: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(state == DPRPD_ST_PPD) |=> !BUFFERS_EN_O && DLL_FROZEN_O)
		else $error("buffers or DLL wrong in precharge power-down");
	AST_PD_EXIT: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		(ck_rise && sync2[8] && (state == DPRPD_ST_PPD || state == DPRPD_ST_APD))
		|=> state == DPRPD_ST_IDLE)
		else $error("power-down exit missed");
	AST_PD_ENTRY: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
		$rose(state == DPRPD_ST_PPD) |-> $past(state) == DPRPD_ST_IDLE)
		else $error("power-down entered from a busy state");

endmodule : dprpd_core
`default_nettype wire

// File: dprpd_consts.svh
// Constants for the precharge, refresh and power-down state block.
// Assumes a 200 MHz core clock; the refresh count is derived from its time here.
`ifndef DPRPD_CONSTS_SVH
`define DPRPD_CONSTS_SVH

`define DPRPD_CLK_PERIOD_PS      5000
`define DPRPD_NUM_BANKS          8
`define DPRPD_BA_W               3
`define DPRPD_ADDR_A10           10
`define DPRPD_MR_SLOW_EXIT_BIT   12
`define DPRPD_CKE_MIN_REG        3
`define DPRPD_RFC_PS             127500
`define DPRPD_RFC_CYC            ((`DPRPD_RFC_PS + `DPRPD_CLK_PERIOD_PS - 1) / `DPRPD_CLK_PERIOD_PS)
`define DPRPD_XSRD_CYC           200
`define DPRPD_CNT_W              9

`endif

// File: dprpd_pkg.sv
// Types shared by the precharge, refresh and power-down state block.
// Assumes the constants header is included by its users.
package dprpd_pkg;

	typedef enum logic [2:0]
	{
		DPRPD_CMD_NOP  = 3'b000,
		DPRPD_CMD_ACT  = 3'b001,
		DPRPD_CMD_PRE  = 3'b010,
		DPRPD_CMD_REF  = 3'b011,
		DPRPD_CMD_RD   = 3'b100,
		DPRPD_CMD_WR   = 3'b101,
		DPRPD_CMD_MRS  = 3'b110,
		DPRPD_CMD_DES  = 3'b111
	} dprpd_cmd_t;

	typedef enum logic [2:0]
	{
		DPRPD_ST_IDLE   = 3'b000,
		DPRPD_ST_REFRESH = 3'b001,
		DPRPD_ST_SELFREF = 3'b010,
		DPRPD_ST_PPD    = 3'b011,
		DPRPD_ST_APD    = 3'b100
	} dprpd_state_t;

	typedef struct packed
	{
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic [2:0] ba;
		logic       a10;
	} dprpd_pins_t;

endpackage : dprpd_pkg

// File: dprpd_ctrl_model.sv
// Memory controller model: makes the memory clock, clock enable and commands.
// Assumes clk_i is the core clock; pins change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module dprpd_ctrl_model
	import dprpd_pkg::*;
(
	input  wire logic        clk_i,
	output var  logic        mem_ck_o,
	output var  logic        cke_o,
	output var  dprpd_pins_t pins_o
);
	initial
	begin
		mem_ck_o = 1'b0;
		cke_o = 1'b1;
		pins_o = 8'h80;
		#1;
		forever #62.5 mem_ck_o = ~mem_ck_o;
	end

	task automatic cmd(input logic cke, input logic [3:0] c, input logic [3:0] ba_a10);
		@(negedge mem_ck_o);
		@(negedge clk_i);
		cke_o = cke;
		pins_o = {c, ba_a10};
		@(negedge mem_ck_o);
		@(negedge clk_i);
		// Released lines show the inverse so a stale value cannot pass.
		pins_o = {1'b1, ~pins_o[6:0]};
	endtask : cmd
endmodule : dprpd_ctrl_model
`default_nettype wire

// File: tb.sv
// Testbench for the bank, refresh and power-down state block.
// Assumes the controller model drives every memory-side pin of the block; core clock and reset come from here.
`timescale 1ns/1ps
`default_nettype none
`include "dprpd_consts.svh"
module tb
	import dprpd_pkg::*;
;
	localparam int RFC_T = 8;
	localparam int XSRD_T = 4;
	localparam logic [3:0] ACT = 4'h3;
	localparam logic [3:0] PRE = 4'h2;
	localparam logic [3:0] REF = 4'h1;
	localparam logic [3:0] NOP = 4'h7;
	logic        clock;
	logic        reset_n;
	logic        mem_ck;
	logic        cke;
	dprpd_pins_t pins;
	logic [7:0]  bank_open;
	logic [2:0]  state;
	logic        busy;
	logic        buf_en;
	logic        dll_frz;
	logic        rd_rdy;
	int          n_mismatch;
	int          n_checks;
	int          busy_cyc;
	logic [31:0] rnd;
	logic [7:0]  exp;
	wire  [7:0]  stat = {1'b0, state, buf_en, dll_frz, rd_rdy, busy};

	dprpd_core #(.RFC_CYC(RFC_T), .XSRD_CYC(XSRD_T)) uut
	(
		.CLOCK_I(clock), .RESET_N_I(reset_n), .MEM_CK_I(mem_ck), .CKE_I(cke),
		.CS_N_I(pins.cs_n), .RAS_N_I(pins.ras_n), .CAS_N_I(pins.cas_n),
		.WE_N_I(pins.we_n), .BA_I(pins.ba), .A10_I(pins.a10),
		.BANK_OPEN_O(bank_open), .STATE_O(state), .REFRESH_BUSY_O(busy),
		.BUFFERS_EN_O(buf_en), .DLL_FROZEN_O(dll_frz), .READ_READY_O(rd_rdy)
	);
	dprpd_ctrl_model m_ctrl (.clk_i(clock), .mem_ck_o(mem_ck), .cke_o(cke), .pins_o(pins));

	always #2.5 clock = ~clock;
	always @(posedge clock) if (busy === 1'b1) busy_cyc++;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [2:0] pd_state(input logic [7:0] o);
		return (o == 8'h00) ? DPRPD_ST_PPD : DPRPD_ST_APD;
	endfunction : pd_state

	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		n_checks++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, want);
		end
	endtask : chk

	task automatic print_verdict();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// An activate inside power-down must be ignored by the block.
	task automatic pd_cycle();
		m_ctrl.cmd(1'b0, NOP, 4'h0);
		chk(stat, {1'b0, pd_state(exp), 1'b0, exp == 8'h00, 2'h2});
		m_ctrl.cmd(1'b0, ACT, {rnd[5:3], 1'b0});
		chk(bank_open, exp);
		m_ctrl.cmd(1'b1, NOP, 4'h0);
		chk(stat, {1'b0, DPRPD_ST_IDLE, 4'ha});
	endtask : pd_cycle

	initial
	begin
		#100_000;
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		clock = 1'b0;
		reset_n = 1'b0;
		n_mismatch = 0;
		n_checks = 0;
		rnd = 32'he27d;
		exp = 8'h00;
		repeat (16) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		chk(stat, {1'b0, DPRPD_ST_IDLE, 4'ha});
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			if (!exp[rnd[2:0]] || i == 0)
			begin
				m_ctrl.cmd(1'b1, ACT, {rnd[2:0], 1'b0});
				exp[rnd[2:0]] = 1'b1;
			end
			chk(bank_open, exp);
		end
		pd_cycle();
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			m_ctrl.cmd(1'b1, PRE, {rnd[2:0], 1'b0});
			exp[rnd[2:0]] = 1'b0;
			chk(bank_open, exp);
		end
		m_ctrl.cmd(1'b1, PRE, {rnd[6:4], 1'b1});
		exp = 8'h00;
		chk(bank_open, exp);
		pd_cycle();
		busy_cyc = 0;
		m_ctrl.cmd(1'b1, REF, 4'h1);
		chk(8'(busy_cyc), 8'(RFC_T));
		m_ctrl.cmd(1'b0, REF, 4'h1);
		m_ctrl.cmd(1'b0, NOP, 4'h0);
		// Self refresh gates the buffers, freezes the loop and blocks reads.
		chk(stat, {1'b0, DPRPD_ST_SELFREF, 4'h4});
		m_ctrl.cmd(1'b1, NOP, 4'h0);
		chk(stat, {1'b0, DPRPD_ST_IDLE, 4'h8});
		// Reads must still be blocked one memory edge before the exit count runs out.
		repeat (XSRD_T - 1) @(posedge mem_ck);
		@(negedge mem_ck);
		chk(stat, {1'b0, DPRPD_ST_IDLE, 4'h8});
		@(posedge mem_ck);
		@(negedge mem_ck);
		chk(stat, {1'b0, DPRPD_ST_IDLE, 4'ha});
		print_verdict();
	end
endmodule : tb
`default_nettype wire
